//--- rtl/status_pkg.sv
package status_pkg;

    localparam int WORD_W = 16;

    typedef enum logic [3:0] {
        CMD_OPER_COND_Q,
        CMD_OPER_MASK_SET,
        CMD_OPER_MASK_Q,
        CMD_OPER_EVENT_Q,
        CMD_PRESET,
        CMD_WARN_EVENT_Q,
        CMD_WARN_COND_Q,
        CMD_WARN_MASK_SET,
        CMD_WARN_MASK_Q
    } cmd_e;

    // operation bit positions
    localparam int OP_SEQUENCE_RUNNING = 14;
    localparam int OP_SEQUENCE_DONE = 12;
    localparam int OP_SAMPLE_DONE = 11;
    localparam int OP_CONST_CURRENT_ACTIVE = 10;
    localparam int OP_PULSE_DONE = 9;
    localparam int OP_CONST_VOLTAGE_ACTIVE = 8;
    localparam int OP_PULSE_ARMED = 6;
    localparam int OP_AWAITING_TRIGGER = 5;

    // warning bit positions
    localparam int WN_ABSORBING_LOAD_ENERGY = 14;
    localparam int WN_CURRENT_FAULT = 13;
    localparam int WN_VOLTAGE_FAULT = 12;
    localparam int WN_FOLLOWER_UNIT_FAULT = 6;
    localparam int WN_OVERTEMP_FAULT = 3;
    localparam int WN_CURRENT_MODE_FAULT = 1;
    localparam int WN_VOLTAGE_MODE_FAULT = 0;

    // which bits may latch into each event word
    localparam logic [WORD_W-1:0] OPER_LATCH_MASK = 16'h5F60;
    localparam logic [WORD_W-1:0] WARN_LATCH_MASK = 16'h3000;

    // preset and reset values of the masks
    localparam logic [WORD_W-1:0] OPER_MASK_PRESET = 16'h2001;
    localparam logic [WORD_W-1:0] WARN_MASK_PRESET = 16'h00FF;
    localparam logic [WORD_W-1:0] OPER_MASK_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] WARN_MASK_RESET = 16'h0000;

    // status byte summary positions
    localparam int SB_OPER_SUMMARY = 7;
    localparam int SB_WARN_SUMMARY = 3;

endpackage

//--- rtl/event_if.sv
`timescale 1ns/10ps
`default_nettype none
interface event_if #(
    parameter int W = 16
);
    logic [W-1:0] cond;
    logic [W-1:0] mask;
    logic rd_clr;
    logic [W-1:0] events;
    logic summary;

    modport owner (output cond, output mask, output rd_clr, input events, input summary);
    modport latch (input cond, input mask, input rd_clr, output events, output summary);
endinterface
`default_nettype wire

//--- rtl/event_latch.sv
`timescale 1ns/10ps
`default_nettype none
module event_latch
    import status_pkg::*;
#(
    parameter int W = 16,
    parameter logic [W-1:0] LATCH_BITS = '1
) (
    input wire logic clk_in,   // system clock
    input wire logic rst_b_in, // synchronous reset, active low
    event_if.latch ev          // condition in, events out
);
    logic [W-1:0] cond_prev_q;
    logic [W-1:0] events_q;
    logic [W-1:0] rise;

    // a bit latches on the rising edge of its condition, only where allowed
    assign rise = ev.cond & ~cond_prev_q & LATCH_BITS;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cond_prev_q <= '0;
        end else begin
            cond_prev_q <= ev.cond;
        end
    end

    // a fresh edge in the reading cycle survives the clear
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            events_q <= '0;
        end else if (ev.rd_clr) begin
            events_q <= rise;
        end else begin
            events_q <= events_q | rise;
        end
    end

    assign ev.events = events_q;
    assign ev.summary = |(events_q & ev.mask);
endmodule
`default_nettype wire

//--- rtl/status_regs.sv
`timescale 1ns/10ps
`default_nettype none
module status_regs
    import status_pkg::*;
(
    input wire logic clk_in,                    // 200 MHz clock
    input wire logic rst_b_in,                  // synchronous reset, active low
    input wire logic cmd_valid_in,              // host command strobe
    input wire cmd_e cmd_code_in,               // command or query code
    input wire logic [WORD_W-1:0] cmd_data_in,  // integer for mask writes
    output logic rsp_valid_out,                 // query answer strobe
    output logic [WORD_W-1:0] rsp_data_out,     // query answer value
    output logic cmd_error_out,                 // unknown code strobe
    output logic [7:0] status_byte_out,         // summary bits 7 and 3
    input wire logic sequence_running_in,       // operation condition
    input wire logic sequence_done_in,          // operation condition
    input wire logic sample_done_in,            // operation condition
    input wire logic const_current_active_in,   // operation condition
    input wire logic pulse_done_in,             // operation condition
    input wire logic const_voltage_active_in,   // operation condition
    input wire logic pulse_armed_in,            // operation condition
    input wire logic awaiting_trigger_in,       // operation condition
    input wire logic absorbing_load_energy_in,  // warning condition
    input wire logic current_fault_in,          // warning condition
    input wire logic voltage_fault_in,          // warning condition
    input wire logic follower_unit_fault_in,    // warning condition
    input wire logic overtemp_fault_in,         // warning condition
    input wire logic current_mode_fault_in,     // warning condition
    input wire logic voltage_mode_fault_in      // warning condition
);
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_ANSWER
    } rsp_state_e;

    event_if #(.W(WORD_W)) oper_ev ();
    event_if #(.W(WORD_W)) warn_ev ();

    logic [WORD_W-1:0] oper_cond_q;
    logic [WORD_W-1:0] warn_cond_q;
    logic [WORD_W-1:0] oper_cond_d;
    logic [WORD_W-1:0] warn_cond_d;
    logic [WORD_W-1:0] oper_mask_q;
    logic [WORD_W-1:0] warn_mask_q;
    logic [WORD_W-1:0] rsp_data_q;
    logic [WORD_W-1:0] rsp_data_d;
    logic rsp_valid_q;
    logic cmd_error_q;
    logic oper_sum_q;
    logic warn_sum_q;
    logic is_query;
    logic is_known;
    rsp_state_e state_q;
    rsp_state_e state_d;

    // true for codes that expect an answer
    function automatic logic query_code(input cmd_e c);
        case (c)
            CMD_OPER_COND_Q,
            CMD_OPER_MASK_Q,
            CMD_OPER_EVENT_Q,
            CMD_WARN_EVENT_Q,
            CMD_WARN_COND_Q,
            CMD_WARN_MASK_Q: query_code = 1'b1;
            default: query_code = 1'b0;
        endcase
    endfunction

    // true for every defined code
    function automatic logic known_code(input cmd_e c);
        case (c)
            CMD_OPER_MASK_SET,
            CMD_WARN_MASK_SET,
            CMD_PRESET: known_code = 1'b1;
            default: known_code = query_code(c);
        endcase
    endfunction

    assign is_query = cmd_valid_in && query_code(cmd_code_in);
    assign is_known = known_code(cmd_code_in);

    // assemble live condition words; unused bits stay zero
    always_comb begin
        oper_cond_d = '0;
        oper_cond_d[OP_SEQUENCE_RUNNING] = sequence_running_in;
        oper_cond_d[OP_SEQUENCE_DONE] = sequence_done_in;
        oper_cond_d[OP_SAMPLE_DONE] = sample_done_in;
        oper_cond_d[OP_CONST_CURRENT_ACTIVE] = const_current_active_in;
        oper_cond_d[OP_PULSE_DONE] = pulse_done_in;
        oper_cond_d[OP_CONST_VOLTAGE_ACTIVE] = const_voltage_active_in;
        oper_cond_d[OP_PULSE_ARMED] = pulse_armed_in;
        oper_cond_d[OP_AWAITING_TRIGGER] = awaiting_trigger_in;
    end

    always_comb begin
        warn_cond_d = '0;
        warn_cond_d[WN_ABSORBING_LOAD_ENERGY] = absorbing_load_energy_in;
        warn_cond_d[WN_CURRENT_FAULT] = current_fault_in;
        warn_cond_d[WN_VOLTAGE_FAULT] = voltage_fault_in;
        warn_cond_d[WN_FOLLOWER_UNIT_FAULT] = follower_unit_fault_in;
        warn_cond_d[WN_OVERTEMP_FAULT] = overtemp_fault_in;
        // both mode faults may stand together while settling
        warn_cond_d[WN_CURRENT_MODE_FAULT] = current_mode_fault_in;
        warn_cond_d[WN_VOLTAGE_MODE_FAULT] = voltage_mode_fault_in;
    end

    // condition words follow the inputs every cycle, never latched
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            oper_cond_q <= '0;
            warn_cond_q <= '0;
        end else begin
            oper_cond_q <= oper_cond_d;
            warn_cond_q <= warn_cond_d;
        end
    end

    // operation mask: write, preset
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            oper_mask_q <= OPER_MASK_RESET;
        end else if (cmd_valid_in && cmd_code_in == CMD_PRESET) begin
            oper_mask_q <= OPER_MASK_PRESET;
        end else if (cmd_valid_in && cmd_code_in == CMD_OPER_MASK_SET) begin
            oper_mask_q <= cmd_data_in;
        end
    end

    // warning mask: write, preset
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            warn_mask_q <= WARN_MASK_RESET;
        end else if (cmd_valid_in && cmd_code_in == CMD_PRESET) begin
            warn_mask_q <= WARN_MASK_PRESET;
        end else if (cmd_valid_in && cmd_code_in == CMD_WARN_MASK_SET) begin
            warn_mask_q <= cmd_data_in;
        end
    end

    assign oper_ev.cond = oper_cond_q;
    assign oper_ev.mask = oper_mask_q;
    assign oper_ev.rd_clr = cmd_valid_in && cmd_code_in == CMD_OPER_EVENT_Q;
    assign warn_ev.cond = warn_cond_q;
    assign warn_ev.mask = warn_mask_q;
    assign warn_ev.rd_clr = cmd_valid_in && cmd_code_in == CMD_WARN_EVENT_Q;

    event_latch #(
        .W(WORD_W),
        .LATCH_BITS(OPER_LATCH_MASK)
    ) u_oper_latch (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .ev(oper_ev)
    );

    event_latch #(
        .W(WORD_W),
        .LATCH_BITS(WARN_LATCH_MASK)
    ) u_warn_latch (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .ev(warn_ev)
    );

    // answer value, taken in the cycle the query arrives
    always_comb begin
        case (cmd_code_in)
            CMD_OPER_COND_Q: rsp_data_d = oper_cond_q;
            CMD_OPER_MASK_Q: rsp_data_d = oper_mask_q;
            CMD_OPER_EVENT_Q: rsp_data_d = oper_ev.events;
            CMD_WARN_EVENT_Q: rsp_data_d = warn_ev.events;
            CMD_WARN_COND_Q: rsp_data_d = warn_cond_q;
            CMD_WARN_MASK_Q: rsp_data_d = warn_mask_q;
            default: rsp_data_d = rsp_data_q;
        endcase
    end

    always_comb begin
        case (state_q)
            ST_IDLE: state_d = is_query ? ST_ANSWER : ST_IDLE;
            ST_ANSWER: state_d = is_query ? ST_ANSWER : ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rsp_data_q <= '0;
        end else if (is_query) begin
            rsp_data_q <= rsp_data_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cmd_error_q <= 1'b0;
        end else begin
            cmd_error_q <= cmd_valid_in && !is_known;
        end
    end

    // summary bits registered so the status byte comes from flip-flops
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            oper_sum_q <= 1'b0;
            warn_sum_q <= 1'b0;
        end else begin
            oper_sum_q <= oper_ev.summary;
            warn_sum_q <= warn_ev.summary;
        end
    end

    assign rsp_valid_q = (state_q == ST_ANSWER);
    assign rsp_valid_out = rsp_valid_q;
    assign rsp_data_out = rsp_data_q;
    assign cmd_error_out = cmd_error_q;

    always_comb begin
        status_byte_out = 8'h00;
        status_byte_out[SB_OPER_SUMMARY] = oper_sum_q;
        status_byte_out[SB_WARN_SUMMARY] = warn_sum_q;
    end
endmodule
`default_nettype wire

//--- tb/status_checker.sv
`timescale 1ns/10ps
`default_nettype none
module status_checker
    import status_pkg::*;
(
    input wire logic clk_in, // clock
    input wire logic rst_b_in, // reset
    input wire logic cmd_valid_in, // strobe
    input wire cmd_e cmd_code_in, // code
    input wire logic [WORD_W-1:0] cmd_data_in, // data
    input wire logic rsp_valid_out, // answer strobe
    input wire logic [WORD_W-1:0] rsp_data_out, // answer
    input wire logic cmd_error_out, // error pulse
    input wire logic [7:0] status_byte_out, // summary
    input wire logic sequence_running_in, // op
    input wire logic sequence_done_in, // op
    input wire logic sample_done_in, // op
    input wire logic const_current_active_in, // op
    input wire logic pulse_done_in, // op
    input wire logic const_voltage_active_in, // op
    input wire logic pulse_armed_in, // op
    input wire logic awaiting_trigger_in, // op
    input wire logic absorbing_load_energy_in, // warn
    input wire logic current_fault_in, // warn
    input wire logic voltage_fault_in, // warn
    input wire logic follower_unit_fault_in, // warn
    input wire logic overtemp_fault_in, // warn
    input wire logic current_mode_fault_in, // warn
    input wire logic voltage_mode_fault_in // warn
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    wire [15:0] opv = {1'h0, sequence_running_in, 1'h0, sequence_done_in, sample_done_in,
        const_current_active_in, pulse_done_in, const_voltage_active_in, 1'h0,
        pulse_armed_in, awaiting_trigger_in, 5'h00};
    wire [15:0] wnv = {1'h0, absorbing_load_energy_in, current_fault_in, voltage_fault_in,
        5'h00, follower_unit_fault_in, 2'h0, overtemp_fault_in, 1'h0,
        current_mode_fault_in, voltage_mode_fault_in};
    wire is_q = cmd_valid_in && (cmd_code_in inside {CMD_OPER_COND_Q, CMD_OPER_MASK_Q,
        CMD_OPER_EVENT_Q, CMD_WARN_EVENT_Q, CMD_WARN_COND_Q, CMD_WARN_MASK_Q});
    wire is_bad = cmd_valid_in && (cmd_code_in > CMD_WARN_MASK_Q);
    wire is_w = cmd_valid_in && !is_q && !is_bad;
    AST_QUERY_ANSWER: assert property (is_q |=> rsp_valid_out && !cmd_error_out)
        else $error("query not answered");
    AST_WRITE_SILENT: assert property (is_w |=> !rsp_valid_out)
        else $error("write answered");
    AST_BAD_CODE: assert property (is_bad |=> cmd_error_out && !rsp_valid_out)
        else $error("unknown code not flagged");
    AST_OPER_COND: assert property (cmd_valid_in && cmd_code_in == CMD_OPER_COND_Q
        && $past(rst_b_in) |=> rsp_data_out == $past(opv, 2))
        else $error("operation condition wrong");
    AST_WARN_COND: assert property (cmd_valid_in && cmd_code_in == CMD_WARN_COND_Q
        && $past(rst_b_in) |=> rsp_data_out == $past(wnv, 2))
        else $error("warning condition wrong");
    AST_OPER_EV_BITS: assert property (cmd_valid_in
        && cmd_code_in == CMD_OPER_EVENT_Q |=> (rsp_data_out & 16'hA09F) == 16'h0000)
        else $error("unused operation event bit");
    AST_WARN_EV_BITS: assert property (cmd_valid_in
        && cmd_code_in == CMD_WARN_EVENT_Q |=> (rsp_data_out & 16'hCFFF) == 16'h0000)
        else $error("non latching warning bit");
    AST_PRESET: assert property (cmd_valid_in && cmd_code_in == CMD_PRESET
        ##1 cmd_valid_in && cmd_code_in == CMD_OPER_MASK_Q |=> rsp_data_out == 16'h2001)
        else $error("preset mask wrong");
    AST_MASK_ECHO: assert property (cmd_valid_in && cmd_code_in == CMD_OPER_MASK_SET
        ##1 cmd_valid_in && cmd_code_in == CMD_OPER_MASK_Q
        |=> rsp_data_out == $past(cmd_data_in, 2))
        else $error("mask readback wrong");
    AST_SB_UNUSED: assert property ((status_byte_out & 8'h77) == 8'h00)
        else $error("unused status byte bit");
    cover property (is_bad);
    cover property (status_byte_out[7]);
    cover property (status_byte_out[3]);
endmodule
bind status_regs status_checker u_chk (.*);
`default_nettype wire

//--- tb/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model
    import status_pkg::*;
(
    input wire logic clk_in, // clock
    input wire logic rsp_valid_out, // answer strobe
    input wire logic [WORD_W-1:0] rsp_data_out, // answer value
    output var logic cmd_valid_out, // command strobe
    output var cmd_e cmd_code_out, // code
    output var logic [WORD_W-1:0] cmd_data_out // mask data
);
    initial begin
        cmd_valid_out = 1'h0;
        cmd_code_out = CMD_OPER_COND_Q;
        cmd_data_out = 16'h0000;
    end
    // tasks start and end just after a falling edge; strobe held until idle
    task automatic send(input cmd_e c, input logic [WORD_W-1:0] d);
        cmd_valid_out = 1'h1;
        cmd_code_out = c;
        cmd_data_out = d;
        @(negedge clk_in);
    endtask
    // event queries consume the latched events
    task automatic query(input cmd_e c, output logic [WORD_W-1:0] d, output logic v);
        send(c, ~cmd_data_out);
        v = rsp_valid_out;
        d = rsp_data_out;
    endtask
    task automatic idle();
        cmd_valid_out = 1'h0;
        cmd_data_out = ~cmd_data_out;
        @(negedge clk_in);
    endtask
endmodule
`default_nettype wire

//--- tb/status_reporting_registers_bench.sv
`timescale 1ns/10ps
`default_nettype none
module status_reporting_registers_bench import status_pkg::*;;
    logic clk_in = 1'h0;
    logic rst_b_in = 1'h0;
    logic cmd_valid_in, rsp_valid_out, cmd_error_out, v;
    cmd_e cmd_code_in;
    logic [15:0] cmd_data_in, rsp_data_out, got;
    logic [7:0] status_byte_out;
    logic [7:0] op_in = 8'h00;
    logic [6:0] wn_in = 7'h00;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    int op_pos[8] = '{14, 12, 11, 10, 9, 8, 6, 5};
    int wn_pos[7] = '{14, 13, 12, 6, 3, 1, 0};
    always #2.5 clk_in = ~clk_in;
    status_regs DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in),
        .cmd_code_in(cmd_code_in), .cmd_data_in(cmd_data_in), .rsp_valid_out(rsp_valid_out),
        .rsp_data_out(rsp_data_out), .cmd_error_out(cmd_error_out),
        .status_byte_out(status_byte_out), .sequence_running_in(op_in[0]),
        .sequence_done_in(op_in[1]), .sample_done_in(op_in[2]),
        .const_current_active_in(op_in[3]), .pulse_done_in(op_in[4]),
        .const_voltage_active_in(op_in[5]), .pulse_armed_in(op_in[6]),
        .awaiting_trigger_in(op_in[7]), .absorbing_load_energy_in(wn_in[0]),
        .current_fault_in(wn_in[1]), .voltage_fault_in(wn_in[2]),
        .follower_unit_fault_in(wn_in[3]), .overtemp_fault_in(wn_in[4]),
        .current_mode_fault_in(wn_in[5]), .voltage_mode_fault_in(wn_in[6]));
    host_model host (.clk_in(clk_in), .rsp_valid_out(rsp_valid_out),
        .rsp_data_out(rsp_data_out), .cmd_valid_out(cmd_valid_in),
        .cmd_code_out(cmd_code_in), .cmd_data_out(cmd_data_in));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic ask(input cmd_e c, input logic [15:0] exp, input string name);
        host.query(c, got, v);
        check({name, " strobe"}, {15'h0000, v}, 16'h0001);
        check(name, got, exp);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles > 3000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        repeat (12) @(negedge clk_in);
        rst_b_in = 1'h1;
        ask(CMD_OPER_MASK_Q, 16'h0000, "op mask reset");
        ask(CMD_WARN_MASK_Q, 16'h0000, "wn mask reset");
        ask(CMD_OPER_EVENT_Q, 16'h0000, "op event reset");
        for (int i = 0; i < 8; i++) begin
            op_in = 8'(1 << i);
            repeat (3) host.idle();
            ask(CMD_OPER_COND_Q, 16'(1 << op_pos[i]), "op cond");
            ask(CMD_OPER_EVENT_Q, 16'(1 << op_pos[i]), "op event");
            ask(CMD_OPER_EVENT_Q, 16'h0000, "op event cleared");
        end
        op_in = 8'h01; // sequence running rises in the cycle its event word is read
        host.idle();
        ask(CMD_OPER_EVENT_Q, 16'h0000, "op event race");
        ask(CMD_OPER_EVENT_Q, 16'h4000, "op event kept");
        op_in = 8'h02; // short sequence done pulse, gone before the read
        host.idle();
        op_in = 8'h00;
        repeat (3) host.idle();
        ask(CMD_OPER_EVENT_Q, 16'h1000, "op event held");
        for (int i = 0; i < 7; i++) begin
            wn_in = 7'(1 << i);
            repeat (3) host.idle();
            ask(CMD_WARN_COND_Q, 16'(1 << wn_pos[i]), "wn cond");
            ask(CMD_WARN_EVENT_Q, (i inside {1, 2}) ? 16'(1 << wn_pos[i]) : 16'h0000,
                "wn event");
            ask(CMD_WARN_EVENT_Q, 16'h0000, "wn event cleared");
        end
        wn_in = 7'h60;
        repeat (3) host.idle();
        ask(CMD_WARN_COND_Q, 16'h0003, "wn settling");
        host.send(CMD_OPER_MASK_SET, 16'hA5C3);
        ask(CMD_OPER_MASK_Q, 16'hA5C3, "op mask");
        host.send(CMD_WARN_MASK_SET, 16'h5A3C);
        ask(CMD_WARN_MASK_Q, 16'h5A3C, "wn mask");
        for (int c = 9; c < 16; c++) begin
            host.send(cmd_e'(c), 16'h0000);
            check("error", {15'h0000, cmd_error_out}, 16'h0001);
        end
        host.send(CMD_OPER_MASK_SET, 16'h0400);
        check("error cleared", {15'h0000, cmd_error_out}, 16'h0000);
        host.send(CMD_WARN_MASK_SET, 16'h2000);
        op_in = 8'h08; // constant current
        wn_in = 7'h02; // current fault
        repeat (4) host.idle();
        check("summary", {8'h00, status_byte_out}, 16'h0088);
        ask(CMD_OPER_EVENT_Q, 16'h0400, "op event");
        ask(CMD_WARN_EVENT_Q, 16'h2000, "wn event");
        repeat (2) host.idle();
        check("summary cleared", {8'h00, status_byte_out}, 16'h0000);
        host.send(CMD_PRESET, 16'h0000);
        ask(CMD_OPER_MASK_Q, 16'h2001, "op preset");
        ask(CMD_WARN_MASK_Q, 16'h00FF, "wn preset");
        op_in = 8'h28; // constant voltage, masked out
        repeat (4) host.idle();
        check("masked summary", {8'h00, status_byte_out}, 16'h0000);
        test_done();
    end
endmodule
`default_nettype wire
